// ---- logic/sfc_device.sv ----
`timescale 1ns/1ps
// ==========================================
// data fifo
module sfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  // fill level
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // full and empty from the pointer pair
  assign count = wr_ptr - rd_ptr;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data = mem[rd_ptr[AW-1:0]];

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'h1;
      if (pop) rd_ptr <= rd_ptr + 1'h1;
    end
  end
endmodule

// ==========================================
// character transmitter
module sfc_tx import sfc_pkg::*; #(
  parameter int BIT_CYC = BIT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // character in
  input wire logic [DATA_BITS-1:0] data,
  input wire logic valid,
  output logic ready,
  // control
  input wire logic allow,
  input wire logic parity_en,
  input wire logic parity_odd,
  // serial out
  output logic line
);
  localparam int CW = $clog2(BIT_CYC);
  if (BIT_CYC < 4) begin : g_chk
    $error("bit period too short");
  end
  sfc_state_e state;
  sfc_state_e next_state;
  logic [CW-1:0] cnt;
  logic [2:0] idx;
  logic [DATA_BITS-1:0] shreg;
  logic par;
  logic pen;
  logic next_line;
  wire bit_end = (cnt == CW'(BIT_CYC - 1));
  wire take = (state == ST_IDLE) && valid && allow;

  // start only while permitted; a started character completes
  assign ready = (state == ST_IDLE) && allow;

  // frame sequence
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (take) next_state = ST_START;
      ST_START: if (bit_end) next_state = ST_DATA;
      ST_DATA: if (bit_end && idx == LAST_BIT) next_state = pen ? ST_PARITY : ST_STOP;
      ST_PARITY: if (bit_end) next_state = ST_STOP;
      ST_STOP: if (bit_end) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // line level per state
  always_comb begin
    unique case (state)
      ST_START: next_line = LINE_START;
      ST_DATA: next_line = shreg[0];
      ST_PARITY: next_line = par;
      default: next_line = LINE_IDLE;
    endcase
  end

  // state, bit timer and shifter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      cnt <= '0;
      idx <= '0;
      shreg <= '0;
      par <= 1'h0;
      pen <= 1'h0;
      line <= LINE_IDLE;
    end else begin
      state <= next_state;
      line <= next_line;
      cnt <= (state == ST_IDLE || bit_end) ? '0 : cnt + 1'h1;
      if (take) begin
        shreg <= data;
        par <= sfc_parity(data, parity_odd);
        pen <= parity_en;
        idx <= '0;
      end else if (state == ST_DATA && bit_end) begin
        shreg <= shreg >> 1; // lsb first
        idx <= idx + 1'h1;
      end
    end
  end
endmodule

// ==========================================
// character receiver
module sfc_rx import sfc_pkg::*; #(
  parameter int BIT_CYC = BIT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // serial in, already synchronised
  input wire logic line,
  // control
  input wire logic parity_en,
  input wire logic parity_odd,
  // character out
  output logic [DATA_BITS-1:0] data,
  output logic valid,
  output logic perr,
  output logic ferr
);
  localparam int CW = $clog2(BIT_CYC);
  sfc_state_e state;
  sfc_state_e next_state;
  logic [CW-1:0] cnt;
  logic [2:0] idx;
  logic pen;
  wire bit_end = (cnt == CW'(BIT_CYC - 1));
  wire half_end = (cnt == CW'(BIT_CYC / 2 - 1));

  // frame sequence; sampling sits mid-bit after the start check
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (line == LINE_START) next_state = ST_START;
      ST_START: if (half_end) next_state = (line == LINE_START) ? ST_DATA : ST_IDLE;
      ST_DATA: if (bit_end && idx == LAST_BIT) next_state = pen ? ST_PARITY : ST_STOP;
      ST_PARITY: if (bit_end) next_state = ST_STOP;
      ST_STOP: if (bit_end) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // state, sampler and status
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      cnt <= '0;
      idx <= '0;
      pen <= 1'h0;
      data <= '0;
      valid <= 1'h0;
      perr <= 1'h0;
      ferr <= 1'h0;
    end else begin
      state <= next_state;
      valid <= 1'h0;
      cnt <= (next_state != state || bit_end) ? '0 : cnt + 1'h1;
      if (state == ST_IDLE) begin
        pen <= parity_en;
        idx <= '0;
        perr <= 1'h0;
      end
      if (state == ST_DATA && bit_end) begin
        data <= {line, data[DATA_BITS-1:1]}; // lsb first
        idx <= idx + 1'h1;
      end
      if (state == ST_PARITY && bit_end) perr <= (line != sfc_parity(data, parity_odd));
      if (state == ST_STOP && bit_end) begin
        valid <= 1'h1;
        ferr <= (line != LINE_IDLE);
      end
    end
  end
endmodule

// ==========================================
// documented device end
module sfc_device import sfc_pkg::*; #(
  parameter int BIT_CYC = BIT_CYCLES,
  parameter int DEPTH = FIFO_DEPTH,
  parameter int MARGIN = RTS_MARGIN
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link
  sfc_link_if.dev link,
  // configuration
  input wire logic parity_en,
  input wire logic parity_odd,
  // characters to send
  input wire logic [DATA_BITS-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // characters received
  output logic [DATA_BITS-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic rx_perr,
  output logic rx_ferr,
  output logic rx_overrun
);
  localparam int FW = DATA_BITS + 2;
  if (MARGIN < 1 || MARGIN >= DEPTH) begin : g_chk
    $error("request margin must leave room in the fifo");
  end
  logic [SYNC_STAGES-1:0] rx_sync;
  logic [SYNC_STAGES-1:0] cts_sync;
  logic rtsn;
  logic ovr;
  logic c_valid;
  logic c_perr;
  logic c_ferr;
  logic f_ready;
  logic [DATA_BITS-1:0] c_data;
  logic [FW-1:0] f_out;
  logic [$clog2(DEPTH):0] f_count;

  // two-stage pin synchronisers; pulled levels at reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_sync <= {SYNC_STAGES{RX_PULL}};
      cts_sync <= {SYNC_STAGES{CTS_PULL}};
    end else begin
      rx_sync <= {rx_sync[0], link.dev_rx};
      cts_sync <= {cts_sync[0], link.dev_cts_n};
    end
  end

  // transmit path, gated by clear-to-send
  sfc_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .clk(clk),
    .resetn(resetn),
    .data(tx_data),
    .valid(tx_valid),
    .ready(tx_ready),
    .allow(cts_sync[1] == HS_ASSERT),
    .parity_en(parity_en),
    .parity_odd(parity_odd),
    .line(link.d2h_data)
  );

  // receive path, runs alongside transmit
  sfc_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .clk(clk),
    .resetn(resetn),
    .line(rx_sync[1]),
    .parity_en(parity_en),
    .parity_odd(parity_odd),
    .data(c_data),
    .valid(c_valid),
    .perr(c_perr),
    .ferr(c_ferr)
  );

  // receive buffer; the user side back-pressures it
  sfc_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(c_valid),
    .in_data({c_ferr, c_perr, c_data}),
    .in_ready(f_ready),
    .out_valid(rx_valid),
    .out_data(f_out),
    .out_ready(rx_ready),
    .count(f_count)
  );
  assign {rx_ferr, rx_perr, rx_data} = f_out;
  assign link.d2h_rts_n = rtsn;
  assign rx_overrun = ovr;

  // request-to-send and overrun flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rtsn <= HS_DEASSERT;
      ovr <= 1'h0;
    end else begin
      rtsn <= (f_count >= ($clog2(DEPTH)+1)'(DEPTH - MARGIN)) ? HS_DEASSERT : HS_ASSERT;
      ovr <= c_valid && !f_ready;
    end
  end
endmodule

// ---- common/sfc_pkg.sv ----
// ==========================================
// serial port constants
package sfc_pkg;
  localparam int CLK_HZ = 200_000_000; // system clock rate
  localparam int BAUD_BPS = 115_200; // default line rate
  localparam int BIT_CYCLES = CLK_HZ / BAUD_BPS; // clocks per bit, rounded down
  localparam int DATA_BITS = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int RTS_MARGIN = 4; // free slots kept for chars in flight
  localparam int SYNC_STAGES = 2;
  localparam logic LINE_IDLE = 1'h1;
  localparam logic LINE_START = 1'h0;
  localparam logic HS_ASSERT = 1'h0;
  localparam logic HS_DEASSERT = 1'h1;
  localparam logic RX_PULL = 1'h1; // pull-up on the receive line
  localparam logic CTS_PULL = 1'h0; // pull-down on clear-to-send
  localparam logic [2:0] LAST_BIT = 3'h7;

  // ==========================================
  // character state, gray along the frame when parity is on
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_DATA = 3'h3,
    ST_PARITY = 3'h2,
    ST_STOP = 3'h6
  } sfc_state_e;

  // parity bit for a character, even or odd
  function automatic logic sfc_parity(input logic [DATA_BITS-1:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction
endpackage

// ---- common/sfc_link_if.sv ----
`timescale 1ns/1ps
// ==========================================
// serial link between the host and the device
interface sfc_link_if;
  import sfc_pkg::*;
  logic h2d_data; // host transmit pin
  logic h2d_oe;
  logic d2h_data; // device transmit pin
  logic d2h_rts_n; // device request-to-send
  logic h_rts_n; // host request, seen as device clear-to-send
  logic h_rts_oe;
  logic dev_rx;
  logic dev_cts_n;

  // pin levels with the device pulls applied
  assign dev_rx = h2d_oe ? h2d_data : RX_PULL;
  assign dev_cts_n = h_rts_oe ? h_rts_n : CTS_PULL;

  modport dev (
    input dev_rx,
    input dev_cts_n,
    output d2h_data,
    output d2h_rts_n
  );
  modport host (
    output h2d_data,
    output h2d_oe,
    output h_rts_n,
    output h_rts_oe,
    input d2h_data,
    input d2h_rts_n
  );
endinterface

// ---- logic/sfc_host.sv ----
`timescale 1ns/1ps
// ==========================================
// host end of the link
module sfc_host import sfc_pkg::*; #(
  parameter int BIT_CYC = BIT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link
  sfc_link_if.host link,
  // configuration
  input wire logic parity_en,
  input wire logic parity_odd,
  input wire logic accept, // host may take characters
  // characters to send
  input wire logic [DATA_BITS-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // characters received
  output logic [DATA_BITS-1:0] rx_data,
  output logic rx_valid,
  output logic rx_perr,
  output logic rx_ferr
);
  logic [SYNC_STAGES-1:0] rx_sync;
  logic [SYNC_STAGES-1:0] rts_sync;
  logic drive;
  logic hrtsn;

  // two-stage pin synchronisers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_sync <= {SYNC_STAGES{LINE_IDLE}};
      rts_sync <= {SYNC_STAGES{HS_DEASSERT}};
    end else begin
      rx_sync <= {rx_sync[0], link.d2h_data};
      rts_sync <= {rts_sync[0], link.d2h_rts_n};
    end
  end

  // pin drive and own request
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      drive <= 1'h0;
      hrtsn <= HS_DEASSERT;
    end else begin
      drive <= 1'h1;
      hrtsn <= accept ? HS_ASSERT : HS_DEASSERT;
    end
  end
  assign link.h2d_oe = drive;
  assign link.h_rts_oe = drive;
  assign link.h_rts_n = hrtsn;

  // transmit, held while the device withdraws its request
  sfc_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .clk(clk),
    .resetn(resetn),
    .data(tx_data),
    .valid(tx_valid),
    .ready(tx_ready),
    .allow(rts_sync[1] == HS_ASSERT),
    .parity_en(parity_en),
    .parity_odd(parity_odd),
    .line(link.h2d_data)
  );

  // receive
  sfc_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .clk(clk),
    .resetn(resetn),
    .line(rx_sync[1]),
    .parity_en(parity_en),
    .parity_odd(parity_odd),
    .data(rx_data),
    .valid(rx_valid),
    .perr(rx_perr),
    .ferr(rx_ferr)
  );
endmodule

// ---- test/sfc_link_chk.sv ----
`timescale 1ns/1ps
// ==========================================
// link checker
module sfc_link_chk import sfc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // link signals
  input wire logic h2d_data,
  input wire logic h2d_oe,
  input wire logic d2h_data,
  input wire logic d2h_rts_n,
  input wire logic h_rts_n,
  input wire logic h_rts_oe,
  input wire logic dev_rx,
  input wire logic dev_cts_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // ==========================================
  // framing, gating and pin defaults
  dev_start_a: assert property ($fell(d2h_data) |-> !d2h_data [*8])
    else $error("device start bit short");
  host_start_a: assert property (h2d_oe && $fell(h2d_data) |-> !h2d_data [*8])
    else $error("host start bit short");
  cts_gate_a: assert property (dev_cts_n [*6] |=> !$fell(d2h_data))
    else $error("device sent while clear deasserted");
  rts_gate_a: assert property (d2h_rts_n [*6] |=> !$fell(dev_rx))
    else $error("host sent while request deasserted");
  rts_ready_a: assert property ($rose(resetn) |-> ##[0:2] d2h_rts_n == HS_ASSERT)
    else $error("request not asserted after reset");
  tx_idle_a: assert property ($rose(resetn) |-> d2h_data [*3])
    else $error("device line not idle after reset");
  rx_pull_a: assert property (!h2d_oe |-> dev_rx == LINE_IDLE)
    else $error("receive line not pulled up");
  cts_pull_a: assert property (!h_rts_oe |-> dev_cts_n == HS_ASSERT)
    else $error("clear line not pulled down");

  // main scenarios reached
  cover property ($fell(d2h_data));
  cover property ($fell(dev_rx));
  cover property ($rose(d2h_rts_n));
endmodule

// ---- test/flow_controlled_serial_port_tb_top.sv ----
`timescale 1ns/1ps
// ==========================================
// two-end serial link bench
module flow_controlled_serial_port_tb_top;
  import sfc_pkg::*;
  localparam int BITC = 16;
  logic clk, resetn, par_en, d_odd, h_odd, accept, d_rx_ready;
  logic [DATA_BITS-1:0] d_tx_data, h_tx_data, d_rx_data, h_rx_data;
  logic d_tx_valid, d_tx_ready, h_tx_valid, h_tx_ready, d_rx_valid, h_rx_valid;
  logic d_rx_perr, d_rx_ferr, d_rx_overrun, h_rx_perr, h_rx_ferr;
  logic [9:0] hq[$];
  bit saw_ovr = 1'b0; // any overrun pulse seen on the device
  int num_errors = 0;
  int n_compared = 0;

  sfc_link_if link ();
  sfc_device #(.BIT_CYC(BITC)) u_sfc_device (.clk(clk), .resetn(resetn), .link(link.dev),
    .parity_en(par_en), .parity_odd(d_odd), .tx_data(d_tx_data), .tx_valid(d_tx_valid),
    .tx_ready(d_tx_ready), .rx_data(d_rx_data), .rx_valid(d_rx_valid),
    .rx_ready(d_rx_ready), .rx_perr(d_rx_perr), .rx_ferr(d_rx_ferr),
    .rx_overrun(d_rx_overrun));
  sfc_host #(.BIT_CYC(BITC)) u_sfc_host (.clk(clk), .resetn(resetn), .link(link.host),
    .parity_en(par_en), .parity_odd(h_odd), .accept(accept), .tx_data(h_tx_data),
    .tx_valid(h_tx_valid), .tx_ready(h_tx_ready), .rx_data(h_rx_data),
    .rx_valid(h_rx_valid), .rx_perr(h_rx_perr), .rx_ferr(h_rx_ferr));
  sfc_link_chk u_sfc_link_chk (.clk(clk), .resetn(resetn), .h2d_data(link.h2d_data),
    .h2d_oe(link.h2d_oe), .d2h_data(link.d2h_data), .d2h_rts_n(link.d2h_rts_n),
    .h_rts_n(link.h_rts_n), .h_rts_oe(link.h_rts_oe), .dev_rx(link.dev_rx),
    .dev_cts_n(link.dev_cts_n));

  // 200 mhz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // host pulses collected as {perr, ferr, data}
  always @(posedge clk) begin
    if (h_rx_valid === 1'b1) hq.push_back({h_rx_perr, h_rx_ferr, h_rx_data});
    if (d_rx_overrun === 1'b1) saw_ovr <= 1'b1;
  end

  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask

  // hold valid until ready is seen at an edge
  task automatic send(input bit host, input logic [DATA_BITS-1:0] b);
    int n;
    n = 0;
    @(posedge clk);
    if (host) begin
      h_tx_data <= b;
      h_tx_valid <= 1'b1;
    end else begin
      d_tx_data <= b;
      d_tx_valid <= 1'b1;
    end
    do begin
      @(negedge clk);
      n++;
    end while ((host ? h_tx_ready : d_tx_ready) !== 1'b1 && n < 2000);
    chk(n < 2000, "send not taken");
    @(posedge clk);
    if (host) h_tx_valid <= 1'b0;
    else d_tx_valid <= 1'b0;
  endtask

  // compare fifo head then pop it
  task automatic dev_take(input logic [DATA_BITS-1:0] exp, input logic perr);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (d_rx_valid !== 1'b1 && n < 2000);
    chk(d_rx_valid === 1'b1 && d_rx_data === exp && d_rx_perr === perr && d_rx_ferr === 1'b0,
      "device rx");
    @(posedge clk);
    d_rx_ready <= 1'b1;
    @(posedge clk);
    d_rx_ready <= 1'b0;
  endtask

  task automatic host_take(input logic [DATA_BITS-1:0] exp, input logic perr);
    int n;
    n = 0;
    while (hq.size() == 0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    chk(hq.size() > 0 && hq[0] === {perr, 1'b0, exp}, "host rx");
    if (hq.size() > 0) void'(hq.pop_front());
  endtask

  task automatic wrap_up();
    $display("TB: %0d compared, %0d errors", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    wrap_up();
  end

  // main sequence
  initial begin
    {resetn, par_en, d_odd, h_odd, d_rx_ready, d_tx_valid, h_tx_valid} = '0;
    {d_tx_data, h_tx_data} = '0;
    accept = 1'b1;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(negedge clk);
    chk(link.d2h_data === LINE_IDLE, "tx not idle");
    chk(link.d2h_rts_n === HS_ASSERT, "rts not asserted");
    // every parity mode, both directions at once
    for (int m = 0; m < 3; m++) begin
      @(posedge clk);
      par_en <= (m != 0);
      d_odd <= (m == 2);
      h_odd <= (m == 2);
      fork
        send(1'b0, 8'ha5 ^ m[7:0]);
        send(1'b1, 8'h3c + m[7:0]);
        dev_take(8'h3c + m[7:0], 1'b0);
        host_take(8'ha5 ^ m[7:0], 1'b0);
      join
      $display("TB: parity mode %0d done", m);
    end
    // parity sense differs between ends
    @(posedge clk);
    d_odd <= 1'b0;
    fork
      send(1'b1, 8'h5a);
      send(1'b0, 8'h81);
      dev_take(8'h5a, 1'b1);
      host_take(8'h81, 1'b1);
    join
    @(posedge clk);
    par_en <= 1'b0;
    $display("TB: parity error test done");
    // host withholds clear
    accept <= 1'b0;
    repeat (4) @(negedge clk);
    chk(d_tx_ready === 1'b0, "tx not held");
    fork
      send(1'b0, 8'h69);
      begin
        repeat (40) @(negedge clk);
        chk(link.d2h_data === LINE_IDLE, "sent while held");
        @(posedge clk);
        accept <= 1'b1;
      end
      host_take(8'h69, 1'b0);
    join
    $display("TB: clear hold test done");
    // fill the receive fifo until the request drops
    for (int i = 0; i < FIFO_DEPTH - RTS_MARGIN; i++) send(1'b1, 8'h10 + i[7:0]);
    repeat (BITC * 14) @(negedge clk);
    chk(link.d2h_rts_n === HS_DEASSERT, "rts not dropped");
    chk(h_tx_ready === 1'b0, "host not held off");
    fork
      send(1'b1, 8'h1c);
      for (int i = 0; i < 13; i++) dev_take(8'h10 + i[7:0], 1'b0);
    join
    @(negedge clk);
    chk(d_rx_valid === 1'b0 && link.d2h_rts_n === HS_ASSERT, "not drained");
    chk(!saw_ovr, "receive overrun with flow control kept");
    $display("TB: fifo fill test done");
    wrap_up();
  end
endmodule
